// *** design/sram_port_pkg.sv ***
`default_nettype none
package sram_port_pkg;
  // ==================================================
  // widths of the wide data configuration
  // ==================================================
  localparam int DATA_WIDTH = 36;                 // wide configuration, four byte lanes
  localparam int ADDR_WIDTH = 18;                 // word address, 256K words
  localparam int LANE_WIDTH = 9;                  // one byte lane incl. parity bit
  localparam int LANE_COUNT = (DATA_WIDTH == 36) ? 4 : 2;
  localparam int BURST_BITS = 2;                  // burst counter spans the two low address bits
  localparam int HIGH_BITS  = ADDR_WIDTH - BURST_BITS;
  localparam int MEM_DEPTH  = 1 << ADDR_WIDTH;
  // ==================================================
  // counts and reset values
  // ==================================================
  localparam logic [1:0] BURST_STEP  = 2'h1;      // one beat per advance
  localparam logic [1:0] BURST_FIRST = 2'h0;      // count at load
  localparam logic [1:0] BUF_EMPTY   = 2'h0;
  localparam logic [1:0] BUF_ONE     = 2'h1;
  localparam logic [1:0] BUF_FULL    = 2'h2;      // two-entry read buffer
  localparam int         DATA_LAG    = 2;         // cycles from capture to data, for reference

  typedef logic [DATA_WIDTH-1:0] word_type;
  typedef logic [ADDR_WIDTH-1:0] addr_type;
  typedef logic [LANE_COUNT-1:0] lane_type;

  // direction of the burst held by the counter
  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_READ,
    BURST_WRITE
  } burst_state_type;
endpackage
`default_nettype wire

// *** design/beat_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// one valid/ready word channel
// ==================================================
interface beat_if;
  import sram_port_pkg::*;
  logic     valid;                                // word offered
  logic     ready;                                // word can be taken
  word_type data;                                 // the word
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** design/beat_buffer.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// two-entry buffer on the read data path
// ==================================================
module beat_buffer (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  beat_if.sink      fill,
  beat_if.source    drain
);
  import sram_port_pkg::*;

  word_type   slot_q [2];                         // slot 0 is the head
  word_type   slot_d [2];
  logic [1:0] count_q;                            // words held
  logic [1:0] count_d;
  logic       push;
  logic       pop;

  // honest flags straight from the count
  assign fill.ready  = (count_q != BUF_FULL);
  assign drain.valid = (count_q != BUF_EMPTY);
  assign drain.data  = slot_q[0];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  // next contents: shift on pop, append behind what remains
  always_comb begin
    slot_d[0] = slot_q[0];
    slot_d[1] = slot_q[1];
    count_d   = count_q;
    if (pop) begin
      slot_d[0] = slot_q[1];
    end
    if (push) begin
      if ((count_q == BUF_EMPTY) || ((count_q == BUF_ONE) && pop)) begin
        slot_d[0] = fill.data;
      end else begin
        slot_d[1] = fill.data;
      end
    end
    unique case ({push, pop})
      2'b10:   count_d = count_q + BUF_ONE;
      2'b01:   count_d = count_q - BUF_ONE;
      default: count_d = count_q;
    endcase
  end

  // registers only; data slots need no reset
  always_ff @(posedge sys_clk) begin
    slot_q[0] <= slot_d[0];
    slot_q[1] <= slot_d[1];
    if (sys_rst) begin
      count_q <= BUF_EMPTY;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

// *** design/pipelined_burst_sram_port.sv ***
// Behaviour
// - load low ends burst, captures new access
// - write enable ignored while advancing
// - burst direction fixed at load
// - four-word burst on two low bits
// - write starts on load and write low
// - lane enables lead write data by one
// - lanes three, four only when wide
// - selects low, high, low; all needed
// - clock gate high freezes every register
// - inactive select at load deselects, bus floats
`timescale 1ns/10ps
`default_nettype none
module pipelined_burst_sram_port (
  input  wire logic                           sys_clk,
  input  wire logic                           sys_rst,
  input  wire sram_port_pkg::addr_type        addr,
  input  wire logic                           load_or_advance_n,
  input  wire logic                           write_en_n,
  input  wire logic [2:0]                     byte_lane_write_n,
  input  wire logic                           byte_lane_four_write_n,
  input  wire logic                           chip_sel_n,
  input  wire logic                           chip_sel_high,
  input  wire logic                           chip_sel_third_n,
  input  wire logic                           clock_gate_n,
  input  wire logic                           burst_interleave,
  input  wire sram_port_pkg::word_type        dq_in,
  output var  sram_port_pkg::word_type        dq_out,
  output var  logic                           dq_oe
);
  import sram_port_pkg::*;
  // sys_rst clears the burst state, the pipeline and the output stage;
  // the storage array keeps its contents across a reset

  // ==================================================
  // decode helpers
  // ==================================================
  // all three selects must be active
  // one inactive select is enough to refuse a load
  function automatic logic chip_selected(input logic sel_n, input logic sel_hi, input logic sel3_n);
    chip_selected = ~sel_n & sel_hi & ~sel3_n;
  endfunction

  // low address bits for beat number step of the burst
  // linear wraps inside the aligned group of four; interleaved flips the
  // low bits by the beat number, so both orders visit all four words
  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] step,
                                           input logic interleave);
    if (interleave) begin
      burst_low = start ^ step;
    end else begin
      burst_low = 2'(start + step);
    end
  endfunction

  // ==================================================
  // declarations
  // ==================================================
  burst_state_type burst_q, burst_d;              // idle or direction of the burst
  logic [HIGH_BITS-1:0] high_q, high_d;           // address bits above the counter
  logic [1:0]  start_q, start_d;                  // low bits of the loaded address
  logic [1:0]  count_q, count_d;                  // beats issued since load
  logic        inter_q, inter_d;                  // burst order latched at load
  logic        new_valid;                         // an access is captured this edge
  logic        new_write;
  addr_type    new_addr;
  logic        s1_valid_q, s1_valid_d;            // loaded at the capture edge
  logic        s1_write_q, s1_write_d;
  addr_type    s1_addr_q, s1_addr_d;
  logic        s2_valid_q, s2_valid_d;            // one edge after capture
  logic        s2_write_q, s2_write_d;
  addr_type    s2_addr_q, s2_addr_d;
  lane_type    s2_lane_n_q, s2_lane_n_d;          // lane enables for the s2 beat
  lane_type    lane_n;                            // lane enables as sampled
  word_type    mem [MEM_DEPTH];                   // the storage array
  word_type    rd_word;                           // array word with write bypass
  word_type    dq_out_d;
  logic        dq_oe_d;
  logic        clk_en;                            // edge is not suspended
  logic        adv;                               // pipeline moves this edge
  logic        s2_store;                          // write beat lands this edge

  // read path into and out of the two-entry buffer
  beat_if fill_ch ();                             // read words into the buffer
  beat_if drain_ch ();                            // read words to the output stage

  // ==================================================
  // input decode and stall
  // ==================================================
  // third and fourth lanes only exist in the wide build
  // the narrow build keeps lanes a and b only; the upper lane pins
  // are then left unread on purpose
  generate
    if (LANE_COUNT == 4) begin : g_wide
      assign lane_n = {byte_lane_four_write_n, byte_lane_write_n};
    end else begin : g_narrow
      assign lane_n = byte_lane_write_n[LANE_COUNT-1:0];
    end
  endgenerate

  // a gated edge is treated as if it never came
  assign clk_en = ~clock_gate_n;
  // nothing below may change state unless clk_en is high
  // full buffer also holds the pipe so no read word is lost;
  // trade-off: a plain stall is simpler than a skid path, and the
  // buffer cannot fill while every read beat drains one edge later
  assign adv      = clk_en & fill_ch.ready;
  assign s2_store = adv & s2_valid_q & s2_write_q;

  // ==================================================
  // burst counter and access capture
  // ==================================================
  // loads on a low load control, otherwise advances the open burst
  always_comb begin
    burst_d   = burst_q;
    high_d    = high_q;
    start_d   = start_q;
    count_d   = count_q;
    inter_d   = inter_q;
    new_valid = 1'b0;
    new_write = 1'b0;
    new_addr  = {high_q, burst_low(start_q, count_q, inter_q)};
    // defaults hold all state, so a gated edge changes nothing
    if (adv) begin
      if (!load_or_advance_n) begin
        // any open burst stops here, selected or not
        if (chip_selected(chip_sel_n, chip_sel_high, chip_sel_third_n)) begin
          burst_d   = write_en_n ? BURST_READ : BURST_WRITE;
          high_d    = addr[ADDR_WIDTH-1:BURST_BITS];
          start_d   = addr[BURST_BITS-1:0];
          count_d   = BURST_FIRST;
          inter_d   = burst_interleave;
          new_valid = 1'b1;
          new_write = ~write_en_n;
          new_addr  = addr;
        end else begin
          // deselect load: no access, any open burst closed
          burst_d = BURST_IDLE;
        end
      end else begin
        // write enable is not looked at on this path
        unique case (burst_q)
          BURST_IDLE: begin
            // nothing open, so an advance is a no-op
            burst_d = BURST_IDLE;
          end
          BURST_READ, BURST_WRITE: begin
            // next beat; direction stays as loaded
            count_d   = count_q + BURST_STEP;
            new_valid = 1'b1;
            new_write = (burst_q == BURST_WRITE);
            new_addr  = {high_q, burst_low(start_q, count_d, inter_q)};
          end
          default: begin
            // unused code, fall back to idle
            burst_d = BURST_IDLE;
          end
        endcase
      end
    end
  end

  // counter registers; a gated edge leaves them alone
  // reset: no burst open, linear order, count at the first beat
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      burst_q <= BURST_IDLE;
      high_q  <= '0;
      start_q <= BURST_FIRST;
      count_q <= BURST_FIRST;
      inter_q <= 1'b0;
    end else begin
      burst_q <= burst_d;
      high_q  <= high_d;
      start_q <= start_d;
      count_q <= count_d;
      inter_q <= inter_d;
    end
  end

  // ==================================================
  // two-stage access pipeline
  // ==================================================
  // stages keep moving after deselect so pending beats finish
  always_comb begin
    s1_valid_d  = s1_valid_q;
    s1_write_d  = s1_write_q;
    s1_addr_d   = s1_addr_q;
    s2_valid_d  = s2_valid_q;
    s2_write_d  = s2_write_q;
    s2_addr_d   = s2_addr_q;
    s2_lane_n_d = s2_lane_n_q;
    if (adv) begin
      // stage one takes the access captured at this edge
      s1_valid_d  = new_valid;
      s1_write_d  = new_write;
      s1_addr_d   = new_addr;
      // stage two takes what stage one held
      s2_valid_d  = s1_valid_q;
      s2_write_d  = s1_write_q;
      s2_addr_d   = s1_addr_q;
      // lane enables ride one edge ahead of their data word
      s2_lane_n_d = lane_n;
    end
  end

  // pipeline registers
  // lane enables reset inactive so no lane is ever written by accident
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_valid_q  <= 1'b0;
      s1_write_q  <= 1'b0;
      s1_addr_q   <= '0;
      s2_valid_q  <= 1'b0;
      s2_write_q  <= 1'b0;
      s2_addr_q   <= '0;
      s2_lane_n_q <= '1;
    end else begin
      s1_valid_q  <= s1_valid_d;
      s1_write_q  <= s1_write_d;
      s1_addr_q   <= s1_addr_d;
      s2_valid_q  <= s2_valid_d;
      s2_write_q  <= s2_write_d;
      s2_addr_q   <= s2_addr_d;
      s2_lane_n_q <= s2_lane_n_d;
    end
  end

  // ==================================================
  // storage array
  // ==================================================
  // limitation: the array is not cleared by reset; a word never written
  // reads back whatever the array held
  // write data lands two edges after capture, lanes masked
  always_ff @(posedge sys_clk) begin
    if (s2_store) begin
      for (int l = 0; l < LANE_COUNT; l++) begin
        if (!s2_lane_n_q[l]) begin
          mem[s2_addr_q][l*LANE_WIDTH +: LANE_WIDTH] <= dq_in[l*LANE_WIDTH +: LANE_WIDTH];
        end
      end
    end
  end

  // a read one beat behind a write to the same word sees the new lanes;
  // without this bypass back-to-back write then read would return stale data
  always_comb begin
    rd_word = mem[s1_addr_q];
    if (s2_store && (s2_addr_q == s1_addr_q)) begin
      for (int l = 0; l < LANE_COUNT; l++) begin
        if (!s2_lane_n_q[l]) begin
          rd_word[l*LANE_WIDTH +: LANE_WIDTH] = dq_in[l*LANE_WIDTH +: LANE_WIDTH];
        end
      end
    end
  end

  // ==================================================
  // read buffer and output stage
  // ==================================================
  // stage one reads the array, the buffer holds the word for one edge,
  // and the output register launches it as the beat leaves stage two;
  // both handshakes are cut on a gated edge so no word moves then
  assign fill_ch.valid  = clk_en & s1_valid_q & ~s1_write_q;
  assign fill_ch.data   = rd_word;
  assign drain_ch.ready = clk_en & s2_valid_q & ~s2_write_q;

  beat_buffer u_read_buffer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .fill    (fill_ch.sink),
    .drain   (drain_ch.source)
  );

  // bus driven only in the slot of a read; writes and deselects float it
  always_comb begin
    dq_out_d = dq_out;
    dq_oe_d  = dq_oe;
    if (clk_en) begin
      // drive follows the beat now in stage two
      dq_oe_d = s2_valid_q & ~s2_write_q;
      // data changes only when a read word is popped
      if (drain_ch.valid && drain_ch.ready) begin
        dq_out_d = drain_ch.data;
      end
    end
  end

  // output registers
  // reset: bus released and data cleared
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else begin
      dq_out <= dq_out_d;
      dq_oe  <= dq_oe_d;
    end
  end
endmodule
`default_nettype wire

// *** sim/sram_port_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module sram_port_sva (
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  input wire logic                    load_or_advance_n,
  input wire logic                    write_en_n,
  input wire logic                    chip_sel_n,
  input wire logic                    chip_sel_high,
  input wire logic                    chip_sel_third_n,
  input wire logic                    clock_gate_n,
  input wire sram_port_pkg::word_type dq_out,
  input wire logic                    dq_oe
);
  import sram_port_pkg::*;
  // ==========
  // decoded edge kinds
  // ==========
  wire logic sel = !chip_sel_n && chip_sel_high && !chip_sel_third_n; // all three needed
  wire logic go  = !clock_gate_n;                         // edge not suspended
  wire logic rd  = go && !load_or_advance_n && sel && write_en_n;
  wire logic wr  = go && !load_or_advance_n && sel && !write_en_n;
  wire logic adv = go && load_or_advance_n;
  wire logic des = go && !load_or_advance_n && !sel;      // deselect load
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // output timing
  // ==========
  a_read_two_late: assert property (rd ##1 go [*2] |=> dq_oe)
    else $error("read beat not driven two edges after load");
  a_write_no_drive: assert property (wr ##1 go [*2] |=> !dq_oe)
    else $error("bus driven for a write beat");
  a_adv_ignores_we: assert property (rd ##1 (adv && !write_en_n) ##1 go [*2] |=> dq_oe)
    else $error("write enable changed a read burst");
  a_write_burst_holds: assert property (wr ##1 (adv && write_en_n) ##1 go [*2] |=> !dq_oe)
    else $error("write burst turned into a read");
  a_deselect_floats: assert property (des ##1 go [*2] |=> !dq_oe)
    else $error("bus driven after deselect");
  a_pending_finishes: assert property (rd ##1 des ##1 go |=> dq_oe)
    else $error("pending read lost at deselect");
  a_gate_freezes: assert property (!go |=> $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved on a suspended edge");
  a_gate_delays_read: assert property (rd ##1 !go ##1 go [*2] |=> dq_oe)
    else $error("suspended edge not skipped by read");
  // main scenarios reached
  c_read_burst: cover property (rd ##1 adv ##1 adv ##1 adv);
  c_write_then_read: cover property (wr ##1 rd);
  c_gated_read: cover property (rd ##1 !go ##1 go);
endmodule
bind pipelined_burst_sram_port sram_port_sva i_sram_port_sva (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .load_or_advance_n(load_or_advance_n),
  .write_en_n(write_en_n), .chip_sel_n(chip_sel_n), .chip_sel_high(chip_sel_high),
  .chip_sel_third_n(chip_sel_third_n), .clock_gate_n(clock_gate_n), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// *** sim/sram_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_model (
  input  wire logic                    sys_clk,
  output var  sram_port_pkg::addr_type addr,
  output var  logic                    load_or_advance_n,
  output var  logic                    write_en_n,
  output var  logic [2:0]              byte_lane_write_n,
  output var  logic                    byte_lane_four_write_n,
  output var  logic [2:0]              chip_sel,
  output var  logic                    clock_gate_n,
  output var  logic                    burst_interleave,
  output var  sram_port_pkg::word_type dq_in
);
  import sram_port_pkg::*;
  lane_type ln_next;                  // lanes for the next enabled edge
  word_type d_next;                   // data two enabled edges behind
  word_type d_mid;                    // data one stage on
  logic     wr_q = 1'b0;              // open burst writes
  // ==========
  // beat issue, called just after a rising edge
  // ==========
  task automatic drive(input logic ld, we, addr_type a, lane_type ln, word_type d,
                       input logic gt, logic [2:0] sl, logic il);
    if (!ld && !gt) wr_q = !we && (sl == 3'h2);
    load_or_advance_n <= ld;
    write_en_n        <= we;
    addr              <= a;
    chip_sel          <= sl;
    clock_gate_n      <= gt;
    burst_interleave  <= il;
    ln_next           <= wr_q ? ln : 4'hf;
    d_next            <= wr_q ? d : ~d_next;         // idle bus flips on every drive call
  endtask
  // lanes one edge, data two edges after the beat; stalls with the gate
  always @(posedge sys_clk) begin
    if (!clock_gate_n) begin
      {byte_lane_four_write_n, byte_lane_write_n} <= ln_next;
      d_mid <= d_next;
      dq_in <= d_mid;
    end
  end
  initial begin
    drive(1'b0, 1'b1, 18'h0_0000, 4'hf, 36'h0_0000_0000, 1'b0, 3'h6, 1'b0);
    {byte_lane_four_write_n, byte_lane_write_n} = 4'hf;
    dq_in = 36'h0_0000_0000;
  end
endmodule
`default_nettype wire

// *** sim/pipelined_burst_sram_port_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module pipelined_burst_sram_port_bench;
  import sram_port_pkg::*;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  addr_type   addr;
  logic       ld_n, we_n, gate_n, il, lane4_n, dq_oe;
  logic [2:0] lanes_n, sel;
  word_type   dq_in, dq_out, p1_d, p2_d, p3_d, cur_d;
  logic       p1_oe = 1'b0, p2_oe = 1'b0, p3_oe = 1'b0, cur_oe = 1'b0; // expected drive, per stage
  logic       mode = 1'b0;                                 // burst order in use
  logic [8:0] salt = 9'h000;                               // makes each burst's data new
  word_type   ref_mem [addr_type];                         // expected contents
  int         bad_count = 0;
  int         comparisons = 0;
  initial forever #10 sys_clk = ~sys_clk;
  pipelined_burst_sram_port i_pipelined_burst_sram_port (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .load_or_advance_n(ld_n), .write_en_n(we_n),
    .byte_lane_write_n(lanes_n), .byte_lane_four_write_n(lane4_n), .chip_sel_n(sel[2]),
    .chip_sel_high(sel[1]), .chip_sel_third_n(sel[0]), .clock_gate_n(gate_n),
    .burst_interleave(il), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  sram_ctrl_model i_sram_ctrl_model (
    .sys_clk(sys_clk), .addr(addr), .load_or_advance_n(ld_n), .write_en_n(we_n),
    .byte_lane_write_n(lanes_n), .byte_lane_four_write_n(lane4_n), .chip_sel(sel),
    .clock_gate_n(gate_n), .burst_interleave(il), .dq_in(dq_in));
  // ==========
  // output judge: an expectation enters at its load edge, due two enabled edges on
  // ==========
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      p1_oe <= 1'b0;
      p2_oe <= 1'b0;
      p3_oe <= 1'b0;
    end else if (gate_n === 1'b0) begin  // suspended edges shift nothing
      p3_oe <= p2_oe;
      p3_d  <= p2_d;
      p2_oe <= p1_oe;
      p2_d  <= p1_d;
      p1_oe <= cur_oe;
      p1_d  <= cur_d;
    end
  end
  // looked at mid-cycle, once the outputs of the last edge have settled
  always @(negedge sys_clk) begin
    if (!sys_rst) begin
      comparisons++;
      if (dq_oe !== p3_oe) begin
        bad_count++;
        $display("Error dq_oe expected %b seen %b", p3_oe, dq_oe);
      end else if (p3_oe && dq_out !== p3_d) begin
        bad_count++;
        $display("Error dq_out expected %h seen %h", p3_d, dq_out);
      end
    end
  end
  // one beat with its expected answer
  task automatic bt(input logic ld, we, addr_type a, lane_type ln, word_type d, logic eo,
                    input word_type ed, logic gt = 1'b0, logic [2:0] sl = 3'h2);
    @(posedge sys_clk);
    i_sram_ctrl_model.drive(ld, we, a, ln, d, gt, sl, mode);
    cur_oe <= eo;
    cur_d  <= ed;
  endtask
  // deselect loads close any burst
  task automatic idle(input int n);
    repeat (n) bt(1'b0, 1'b1, 18'h0_0000, 4'hf, 36'h0_0000_0000, 1'b0, 36'h0_0000_0000, 1'b0, 3'h6);
  endtask
  function automatic logic [1:0] nx(input logic [1:0] s, input logic [1:0] k);
    return mode ? (s ^ k) : (s + k);
  endfunction
  // n beats from one load; advances drive a junk address and the given write enable
  task automatic burst(input logic wr, addr_type a, int n, logic awe);
    addr_type x;
    word_type d;
    salt = salt + 9'h001;
    for (int k = 0; k < n; k++) begin
      x = {a[ADDR_WIDTH-1:2], nx(a[1:0], k[1:0])};
      d = {x, x} ^ {4{salt}};
      if (wr) ref_mem[x] = d;
      bt(k != 0, k ? awe : !wr, k ? ~x : x, wr ? 4'h0 : 4'hf, d, !wr, wr ? d : ref_mem[x]);
    end
  endtask
  // both orders, write then read at another start, wrapping past four
  task automatic t_order;
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      burst(1'b1, 18'h0_1231, 4, 1'b1);
      burst(1'b0, 18'h0_1232, 6, 1'b0);
      idle(4);
    end
    $display("t_order done");
  endtask
  // partial lane writes, read straight after
  task automatic t_lanes;
    addr_type a;
    word_type m;
    word_type d;
    lane_type mk;
    a = 18'h0_0400;
    burst(1'b1, a, 1, 1'b1);
    for (int j = 0; j < 2; j++) begin
      mk = j ? 4'h7 : 4'ha;
      m  = ref_mem[a];
      d  = ~m;
      for (int l = 0; l < LANE_COUNT; l++) if (!mk[l]) m[LANE_WIDTH*l +: LANE_WIDTH] = d[LANE_WIDTH*l +: LANE_WIDTH];
      ref_mem[a] = m;
      bt(1'b0, 1'b0, a, mk, d, 1'b0, d);
      burst(1'b0, a, 1, 1'b0);
    end
    idle(4);
    $display("t_lanes done");
  endtask
  // each select inactive in turn, straight after a read
  task automatic t_desel;
    mode = 1'b0;
    for (int i = 0; i < 3; i++) begin
      burst(1'b0, 18'h0_1232, 1, 1'b0);
      bt(1'b0, 1'b1, 18'h0_1233, 4'hf, 36'h0_0000_0000, 1'b0, 36'h0_0000_0000, 1'b0, 3'h2 ^ (3'h4 >> i));
      bt(1'b1, 1'b1, 18'h0_1233, 4'hf, 36'h0_0000_0000, 1'b0, 36'h0_0000_0000);
    end
    idle(4);
    $display("t_desel done");
  endtask
  // suspended edges inside a read burst and while data is out
  task automatic t_gate;
    mode = 1'b0;
    burst(1'b0, 18'h0_1230, 1, 1'b0);
    bt(1'b1, 1'b0, 18'h0_0000, 4'hf, 36'h0_0000_0000, 1'b0, 36'h0_0000_0000, 1'b1);
    bt(1'b1, 1'b1, 18'h0_0000, 4'hf, 36'h0_0000_0000, 1'b1, ref_mem[18'h0_1231]);
    idle(1);
    repeat (2) bt(1'b0, 1'b0, 18'h0_0000, 4'hf, 36'h0_0000_0000, 1'b0, 36'h0_0000_0000, 1'b1);
    idle(4);
    $display("t_gate done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_order();
    t_lanes();
    t_desel();
    t_gate();
    finish_test();
  end
endmodule
`default_nettype wire
